// File: hw/scr_map.svh
// register offsets, field positions, reset values and address ranges of the system control block
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// axi4-lite byte offsets
`define SCR_OFF_SYSCTL       8'h00
`define SCR_OFF_MODECFG      8'h04
`define SCR_OFF_IRQ_STATUS   8'h08
`define SCR_OFF_IRQ_CLEAR    8'h0C
`define SCR_OFF_IRQ_ENABLE   8'h10

// system_control field positions
`define SCR_BIT_RSVD7        7
`define SCR_BIT_STROBE_SEL   6
`define SCR_BIT_IRQ_MODE_HI  5
`define SCR_BIT_IRQ_MODE_LO  4
`define SCR_BIT_RESET_SRC    3
`define SCR_BIT_NMI_EDGE     2
`define SCR_BIT_WINDOW_SEL   1
`define SCR_BIT_RAM_ENABLE   0

// system_control values
`define SCR_SYSCTL_RESET     8'h09
`define SCR_SYSCTL_WDT_RESET 8'h01
`define SCR_SYSCTL_WMASK     8'hD7

// mode_config fields
`define SCR_BIT_EXT_MODE     0
`define SCR_BIT_MODE_PIN_LO  1
`define SCR_BIT_MODE_PIN_HI  2
`define SCR_MODE_PINS_MODE1  2'h1

// event bits of the interrupt registers
`define SCR_NUM_EV           2
`define SCR_EV_NMI           0
`define SCR_EV_BAD_IRQ_MODE  1

// cpu address ranges, low 16 bits of the address
`define SCR_IO_STROBE_LO     16'hF000
`define SCR_IO_STROBE_HI     16'hF7FF
`define SCR_WIN_A_LO         16'hFFF0
`define SCR_WIN_A_HI         16'hFFF7
`define SCR_WIN_B_LO         16'hFFFC
`define SCR_WIN_B_HI         16'hFFFF

// axi responses
`define SCR_RESP_OKAY        2'h0
`define SCR_RESP_SLVERR      2'h2

`endif

// File: hw/scr_pkg.sv
// types of the system control block
package scr_pkg;

  typedef struct packed {
    logic       nmi_s1;
    logic       nmi_s2;
    logic       nmi_prev;
    logic [1:0] md_s1;
    logic [1:0] md_s2;
    logic [7:0] sysctl;
    logic       extended_mode_enable;
    logic       ext_mode;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic       irq;
    logic       nmi_request;
    logic       strobe_pin_n;
    logic       aux_timer_sel;
    logic       keypad_sel;
    logic       ram_sel;
    logic       awready;
    logic       aw_got;
    logic [7:0] awaddr;
    logic       wready;
    logic       w_got;
    logic [7:0] wdata;
    logic       wlane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } scr_state_s;

endpackage : scr_pkg

// File: hw/scr_system_control.sv
// system control register bank with axi4-lite slave, strobe pin, window and ram select
`timescale 1ns/10ps
`default_nettype none
`include "scr_map.svh"

module scr_system_control
  import scr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // chip side
  input  wire logic        wdt_overflow,
  input  wire logic [1:0]  mode_pins,
  input  wire logic        nmi_pin,
  input  wire logic        cpu_access,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_external,
  input  wire logic        cpu_ram_hit,
  output var  logic        strobe_pin_n,
  output var  logic [1:0]  irq_mode,
  output var  logic        nmi_request,
  output var  logic        extended_mode,
  output var  logic        aux_timer_sel,
  output var  logic        keypad_sel,
  output var  logic        onchip_ram_sel,
  output var  logic        onchip_ram_enable,
  output var  logic        irq
);

  scr_state_s st;
  scr_state_s next_st;
  scr_state_s rst_st;

  logic       mode1;
  logic       ext_mode;
  logic       nmi_rise;
  logic       nmi_fall;
  logic       nmi_event;
  logic       in_io_range;
  logic       in_window;
  logic       do_write;
  logic       do_read;
  logic       bad_mode;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  logic [7:0] rd_val;
  logic       rd_ok;
  logic       wr_ok;

  // reset image of the whole state
  always_comb begin
    rst_st              = '0;
    rst_st.sysctl       = `SCR_SYSCTL_RESET;
    rst_st.strobe_pin_n = 1'b1;
    rst_st.awready      = 1'b1;
    rst_st.wready       = 1'b1;
    rst_st.arready      = 1'b1;
  end

  // extended mode and address decode of the current cpu access
  always_comb begin
    mode1       = (st.md_s2 == `SCR_MODE_PINS_MODE1);
    ext_mode    = mode1 | st.extended_mode_enable;
    in_io_range = (cpu_addr >= `SCR_IO_STROBE_LO) && (cpu_addr <= `SCR_IO_STROBE_HI);
    in_window   = ((cpu_addr >= `SCR_WIN_A_LO) && (cpu_addr <= `SCR_WIN_A_HI)) ||
                  ((cpu_addr >= `SCR_WIN_B_LO) && (cpu_addr <= `SCR_WIN_B_HI));
    nmi_rise    = st.nmi_s2 & ~st.nmi_prev;
    nmi_fall    = ~st.nmi_s2 & st.nmi_prev;
    nmi_event   = st.sysctl[`SCR_BIT_NMI_EDGE] ? nmi_rise : nmi_fall;
  end

  // register read value
  always_comb begin
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      `SCR_OFF_SYSCTL: begin
        rd_val = st.sysctl;
      end
      `SCR_OFF_MODECFG: begin
        rd_val[`SCR_BIT_EXT_MODE]    = ext_mode;
        rd_val[`SCR_BIT_MODE_PIN_LO] = st.md_s2[0];
        rd_val[`SCR_BIT_MODE_PIN_HI] = st.md_s2[1];
      end
      `SCR_OFF_IRQ_STATUS: begin
        rd_val[`SCR_NUM_EV-1:0] = st.irq_stat;
      end
      `SCR_OFF_IRQ_CLEAR: begin
        rd_val = 8'h00;
      end
      `SCR_OFF_IRQ_ENABLE: begin
        rd_val[`SCR_NUM_EV-1:0] = st.irq_en;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // write decode, valid only when both address and data are held
  always_comb begin
    do_write = st.aw_got & st.w_got & ~st.bvalid;
    wr_ok    = (st.awaddr == `SCR_OFF_SYSCTL) || (st.awaddr == `SCR_OFF_MODECFG) ||
               (st.awaddr == `SCR_OFF_IRQ_STATUS) || (st.awaddr == `SCR_OFF_IRQ_CLEAR) ||
               (st.awaddr == `SCR_OFF_IRQ_ENABLE);
    bad_mode = do_write & st.wlane0 & (st.awaddr == `SCR_OFF_SYSCTL) &
               st.wdata[`SCR_BIT_IRQ_MODE_HI];
    ev_clr   = '0;
    if (do_write && st.wlane0 && (st.awaddr == `SCR_OFF_IRQ_CLEAR)) begin
      ev_clr = st.wdata[`SCR_NUM_EV-1:0];
    end
    ev_set                       = '0;
    ev_set[`SCR_EV_NMI]          = nmi_event;
    ev_set[`SCR_EV_BAD_IRQ_MODE] = bad_mode;
    do_read  = st.arready & s_axi_arvalid;
  end

  // next state
  always_comb begin
    next_st = st;

    // pin synchronisers
    next_st.nmi_s1   = nmi_pin;
    next_st.nmi_s2   = st.nmi_s1;
    next_st.nmi_prev = st.nmi_s2;
    next_st.md_s1    = mode_pins;
    next_st.md_s2    = st.md_s1;

    // write channel capture, address and data in either order
    if (st.awready && s_axi_awvalid) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (st.wready && s_axi_wvalid) begin
      next_st.w_got  = 1'b1;
      next_st.wdata  = s_axi_wdata[7:0];
      next_st.wlane0 = s_axi_wstrb[0];
    end

    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = wr_ok ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
      if (st.wlane0) begin
        unique case (st.awaddr)
          `SCR_OFF_SYSCTL: begin
            // read-only bits 5 and 3 keep their value, so modes 10 and 11 cannot be set
            next_st.sysctl = (st.sysctl & ~`SCR_SYSCTL_WMASK) |
                             (st.wdata & `SCR_SYSCTL_WMASK);
          end
          `SCR_OFF_MODECFG: begin
            next_st.extended_mode_enable = st.wdata[`SCR_BIT_EXT_MODE];
          end
          `SCR_OFF_IRQ_ENABLE: begin
            next_st.irq_en = st.wdata[`SCR_NUM_EV-1:0];
          end
          default: begin
            next_st.extended_mode_enable = st.extended_mode_enable;
          end
        endcase
      end
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = ~next_st.aw_got & ~next_st.bvalid;
    next_st.wready  = ~next_st.w_got & ~next_st.bvalid;

    // read channel: one read at a time, answered the cycle after it is taken
    if (do_read) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rdata   = rd_val;
      next_st.rresp   = rd_ok ? `SCR_RESP_OKAY : `SCR_RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end

    // sticky events, a set in the clearing cycle wins
    next_st.irq_stat    = (st.irq_stat & ~ev_clr) | ev_set;
    next_st.irq         = |(next_st.irq_stat & next_st.irq_en);
    next_st.nmi_request = nmi_event;

    // strobe pin: address strobe or io strobe, only in extended mode
    next_st.strobe_pin_n = 1'b1;
    if (ext_mode && cpu_access) begin
      if (st.sysctl[`SCR_BIT_STROBE_SEL]) begin
        next_st.strobe_pin_n = ~in_io_range;
      end else begin
        next_st.strobe_pin_n = ~cpu_external;
      end
    end

    // shared windows and ram gating
    next_st.aux_timer_sel = cpu_access & in_window & ~st.sysctl[`SCR_BIT_WINDOW_SEL];
    next_st.keypad_sel    = cpu_access & in_window & st.sysctl[`SCR_BIT_WINDOW_SEL];
    next_st.ram_sel       = cpu_access & cpu_ram_hit & st.sysctl[`SCR_BIT_RAM_ENABLE];

    // watchdog overflow resets the chip but leaves the source flag at zero
    if (wdt_overflow) begin
      next_st        = rst_st;
      next_st.sysctl = `SCR_SYSCTL_WDT_RESET;
      next_st.nmi_s1 = st.nmi_s1;
      next_st.nmi_s2 = st.nmi_s2;
      next_st.md_s1  = st.md_s1;
      next_st.md_s2  = st.md_s2;
    end

    // registered effective extended mode, so the output pin comes from a flop
    next_st.ext_mode = (next_st.md_s2 == `SCR_MODE_PINS_MODE1) | next_st.extended_mode_enable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= rst_st;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    s_axi_awready     = st.awready;
    s_axi_wready      = st.wready;
    s_axi_bvalid      = st.bvalid;
    s_axi_bresp       = st.bresp;
    s_axi_arready     = st.arready;
    s_axi_rvalid      = st.rvalid;
    s_axi_rresp       = st.rresp;
    s_axi_rdata       = {24'h00_0000, st.rdata};
    strobe_pin_n      = st.strobe_pin_n;
    irq_mode          = {st.sysctl[`SCR_BIT_IRQ_MODE_HI], st.sysctl[`SCR_BIT_IRQ_MODE_LO]};
    nmi_request       = st.nmi_request;
    extended_mode     = st.ext_mode;
    aux_timer_sel     = st.aux_timer_sel;
    keypad_sel        = st.keypad_sel;
    onchip_ram_sel    = st.ram_sel;
    onchip_ram_enable = st.sysctl[`SCR_BIT_RAM_ENABLE];
    irq               = st.irq;
  end

endmodule : scr_system_control
`default_nettype wire

// File: verif/scr_monitor.sv
// assertion checker for the system control block
`timescale 1ns/10ps
`default_nettype none
`include "scr_map.svh"
module scr_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        wdt_overflow,
  input wire logic [1:0]  mode_pins,
  input wire logic        nmi_pin,
  input wire logic        cpu_access,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_external,
  input wire logic        cpu_ram_hit,
  input wire logic        strobe_pin_n,
  input wire logic [1:0]  irq_mode,
  input wire logic        nmi_request,
  input wire logic        extended_mode,
  input wire logic        aux_timer_sel,
  input wire logic        keypad_sel,
  input wire logic        onchip_ram_sel,
  input wire logic        onchip_ram_enable
);
  logic [2:0] up;
  logic       io_hit;
  logic       win_hit;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign io_hit  = cpu_addr >= `SCR_IO_STROBE_LO && cpu_addr <= `SCR_IO_STROBE_HI;
  assign win_hit = (cpu_addr >= `SCR_WIN_A_LO && cpu_addr <= `SCR_WIN_A_HI)
                   || cpu_addr >= `SCR_WIN_B_LO;
  // cycles since the last reset of any kind, so synchronisers have settled
  always_ff @(posedge aclk) begin
    if (!aresetn || wdt_overflow)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  end
  mode_ro_a: assert property (irq_mode[1] == 1'b0)
    else $error("irq mode upper bit set");
  ram_rst_a: assert property (disable iff (1'b0) !aresetn |=> onchip_ram_enable)
    else $error("ram not enabled by reset");
  strobe_src_a: assert property (!strobe_pin_n |->
      $past(cpu_access && extended_mode && (cpu_external || io_hit)))
    else $error("strobe without cause");
  io_strobe_a: assert property (
      $past(cpu_access && cpu_external && extended_mode && io_hit) |-> !strobe_pin_n)
    else $error("strobe missing in io range");
  win_one_a: assert property ($past(cpu_access && win_hit) |->
      aux_timer_sel != keypad_sel)
    else $error("window group select wrong");
  ram_gate_a: assert property (
      onchip_ram_sel == $past(cpu_access && cpu_ram_hit && onchip_ram_enable))
    else $error("ram select wrong");
  nmi_src_a: assert property (nmi_request |->
      $past(nmi_pin, 3) != $past(nmi_pin, 4))
    else $error("nmi request without edge");
  mode1_ext_a: assert property (up == 3'h7 && $past(mode_pins, 2) == 2'h1
      && $past(mode_pins, 3) == 2'h1 && $past(mode_pins, 4) == 2'h1 |-> extended_mode)
    else $error("mode 1 not extended");
endmodule : scr_monitor
bind scr_system_control scr_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .wdt_overflow(wdt_overflow), .mode_pins(mode_pins),
  .nmi_pin(nmi_pin), .cpu_access(cpu_access), .cpu_addr(cpu_addr),
  .cpu_external(cpu_external), .cpu_ram_hit(cpu_ram_hit), .strobe_pin_n(strobe_pin_n),
  .irq_mode(irq_mode), .nmi_request(nmi_request), .extended_mode(extended_mode),
  .aux_timer_sel(aux_timer_sel), .keypad_sel(keypad_sel), .onchip_ram_sel(onchip_ram_sel),
  .onchip_ram_enable(onchip_ram_enable));
`default_nettype wire

// File: verif/tb.sv
// self-checking bench of the system control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        aclk, aresetn, awv, awr, wv, wrd, bv, brd, arv, ard, rv, rrd;
  logic        wdt, nmi, ca, ce, ch, sn, nr, em, ats, kps, rs, re, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws;
  logic [1:0]  bres, rres, mp, im;
  logic [15:0] cadr;
  logic [33:0] q[$];
  int          err_count, n_compared, seed;
  scr_system_control dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bres), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ard), .s_axi_rdata(rd),
    .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rrd), .wdt_overflow(wdt),
    .mode_pins(mp), .nmi_pin(nmi), .cpu_access(ca), .cpu_addr(cadr),
    .cpu_external(ce), .cpu_ram_hit(ch), .strobe_pin_n(sn), .irq_mode(im),
    .nmi_request(nr), .extended_mode(em), .aux_timer_sel(ats), .keypad_sel(kps),
    .onchip_ram_sel(rs), .onchip_ram_enable(re), .irq(irq));
  always #20 aclk = ~aclk;
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // bus responses are compared in order against the notes left by the tasks
  always @(posedge aclk) begin
    if (bv && brd) chk("bresp", q.pop_front(), {bres, 32'h0});
    if (rv && rrd) chk("rdata", q.pop_front(), {rres, rd});
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    q.push_back({r, 32'h0});
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    brd <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    q.push_back({26'h0, e});
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge aclk);
      if (ard) arv <= 1'b0;
    end while (!rv);
    rrd <= 1'b0;
  endtask : rdc
  // x holds the expected strobe, aux, keypad and ram selects
  task automatic cpu(input logic [15:0] a, input logic e, input logic h, input logic [3:0] x);
    @(posedge aclk);
    ca <= 1'b1;
    cadr <= a;
    ce <= e;
    ch <= h;
    @(posedge aclk);
    ca <= 1'b0;
    #1 chk("pins", {30'h0, x}, {30'h0, sn, ats, kps, rs});
  endtask : cpu
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    wrap_up();
  end
  initial begin
    logic [7:0] d;
    {aclk, aresetn, awv, wv, brd, arv, rrd, wdt, nmi, ca, ce, ch} = '0;
    {awa, ara, wd, cadr} = '0;
    ws = 4'h1;
    mp = 2'h1;
    err_count = 0;
    n_compared = 0;
    seed = 77090;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h00, 8'h09);
    rdc(8'h04, 8'h03);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed)) & 8'h57;
      wr(8'h00, d);
      rdc(8'h00, d | 8'h08);
      #1 chk("mode", {32'h0, d[5:4]}, {32'h0, im});
      chk("ram_en", {33'h0, d[0]}, {33'h0, re});
    end
    wr(8'h20, 8'hFF, 2'h2);
    wr(8'h10, 8'h02);
    wr(8'h00, 8'h21);
    rdc(8'h00, 8'h09);
    rdc(8'h08, 8'h02);
    #1 chk("irq", 34'h1, {33'h0, irq});
    wr(8'h10, 8'h00);
    repeat (2) @(posedge aclk);
    #1 chk("irq", 34'h0, {33'h0, irq});
    wr(8'h0C, 8'h02);
    rdc(8'h08, 8'h00);
    wr(8'h10, 8'h01);
    nmi <= 1'b1;
    repeat (6) @(posedge aclk);
    rdc(8'h08, 8'h00);
    nmi <= 1'b0;
    repeat (6) @(posedge aclk);
    rdc(8'h08, 8'h01);
    wr(8'h0C, 8'h01);
    wr(8'h00, 8'h05);
    nmi <= 1'b1;
    repeat (6) @(posedge aclk);
    rdc(8'h08, 8'h01);
    nmi <= 1'b0;
    wr(8'h0C, 8'h01);
    wr(8'h00, 8'h01);
    cpu(16'h1234, 1'b1, 1'b0, 4'h0);
    cpu(16'hFFF0, 1'b0, 1'b0, 4'hC);
    cpu(16'h0100, 1'b0, 1'b1, 4'h9);
    wr(8'h00, 8'h42);
    cpu(16'hF7FF, 1'b1, 1'b0, 4'h0);
    cpu(16'hF800, 1'b1, 1'b0, 4'h8);
    cpu(16'hFFFC, 1'b0, 1'b0, 4'hA);
    cpu(16'hFFF8, 1'b0, 1'b0, 4'h8);
    cpu(16'h0100, 1'b0, 1'b1, 4'h8);
    @(posedge aclk);
    wdt <= 1'b1;
    @(posedge aclk);
    wdt <= 1'b0;
    repeat (2) @(posedge aclk);
    rdc(8'h00, 8'h01);
    #1 chk("ram_en", 34'h1, {33'h0, re});
    mp <= 2'h2;
    repeat (5) @(posedge aclk);
    rdc(8'h04, 8'h04);
    wr(8'h04, 8'h01);
    rdc(8'h04, 8'h05);
    ws <= 4'h0;
    wr(8'h00, 8'h40);
    ws <= 4'h1;
    rdc(8'h00, 8'h01);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
